// File: bfo_exec.sv
// execution unit for bit, branch, call, clear and flag-clear operations with an AXI4-Lite register port
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module bfo_exec (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             busy,
    output logic             push_strobe,
    output logic [15:0]      push_addr,
    output logic [15:0]      push_data,
    output logic [15:0]      program_counter
);
    import bfo_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_CALL_SP, ST_CALL_PUSH, ST_CALL_PC} bfo_state_t;

    // merge a 32-bit bus write into a 16-bit register under byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    // negative, zero and carry-as-not-zero of a logic result at the chosen size
    function automatic bfo_flags_t logic_flags(input logic [15:0] r, input logic b);
        logic zr;
        zr = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
        logic_flags.n = b ? r[7] : r[15];
        logic_flags.z = zr;
        logic_flags.c = ~zr;
        logic_flags.v = 1'b0;
    endfunction

    // registers
    bfo_state_t  state_reg, state_next;
    bfo_ctrl_t   ctrl_reg;
    logic [15:0] src_reg, dst_reg, status_reg, pc_reg, sp_reg, tmp_reg;
    logic [15:0] push_addr_reg, push_data_reg;
    logic        push_strobe_reg;
    logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // bus decode
    wire         wr_fire   = awready_reg & wready_reg;
    wire         rd_fire   = arready_reg;
    wire         idle      = (state_reg == ST_IDLE);
    wire         wr_ctrl   = wr_fire & (s_axi_awaddr == CTRL_OFS);
    wire         wr_src    = wr_fire & (s_axi_awaddr == SRC_OFS) & idle;
    wire         wr_dst    = wr_fire & (s_axi_awaddr == DST_OFS) & idle;
    wire         wr_status = wr_fire & (s_axi_awaddr == STATUS_OFS) & idle;
    wire         wr_pc     = wr_fire & (s_axi_awaddr == PC_OFS) & idle;
    wire         wr_sp     = wr_fire & (s_axi_awaddr == SP_OFS) & idle;
    wire         wr_mapped = (s_axi_awaddr == CTRL_OFS) | (s_axi_awaddr == SRC_OFS) | (s_axi_awaddr == DST_OFS)
                           | (s_axi_awaddr == STATUS_OFS) | (s_axi_awaddr == PC_OFS) | (s_axi_awaddr == SP_OFS)
                           | (s_axi_awaddr == PUSH_ADDR_OFS) | (s_axi_awaddr == PUSH_DATA_OFS);
    wire         go        = wr_ctrl & idle & s_axi_wstrb[1] & s_axi_wdata[CTRL_GO_BIT];
    wire         ctrl_load = wr_ctrl & idle & s_axi_wstrb[0];
    wire [15:0]  ctrl_rd   = {2'b00, ctrl_reg.len_words, 2'b00, ~idle, 1'b0,
                              3'b000, ctrl_reg.byte_op, ctrl_reg.op};

    // operand shaping: byte size keeps the destination high byte, word is all 16 bits
    wire         byte_sel  = ctrl_reg.byte_op;
    wire [15:0]  size_mask = byte_sel ? 16'h00FF : 16'hFFFF;
    wire [15:0]  src_v     = src_reg & size_mask;
    wire [15:0]  dst_hi    = dst_reg & ~size_mask;

    // result values of the data operations
    wire [15:0]  clr_res   = (~src_reg & dst_reg) & size_mask;
    wire [15:0]  set_res   = (src_reg | dst_reg) & size_mask;
    wire [15:0]  and_res   = (src_reg & dst_reg) & size_mask;
    wire [16:0]  cmp_sum   = {1'b0, dst_reg & size_mask} + {1'b0, ~src_reg & size_mask} + 17'h00001;
    wire         cmp_carry = byte_sel ? cmp_sum[8] : cmp_sum[16];
    wire         cmp_sgn_d = byte_sel ? dst_reg[7] : dst_reg[15];
    wire         cmp_sgn_s = byte_sel ? src_reg[7] : src_reg[15];
    wire         cmp_sgn_r = byte_sel ? cmp_sum[7] : cmp_sum[15];
    wire [15:0]  ret_addr  = pc_reg + {13'h0000, ctrl_reg.len_words, 1'b0};
    wire [15:0]  sp_dec    = sp_reg - SP_STEP;

    // flags of logic and compare results
    bfo_flags_t  and_flags, cmp_flags;
    assign and_flags   = logic_flags(and_res, byte_sel);
    assign cmp_flags.n = cmp_sgn_r;
    assign cmp_flags.z = byte_sel ? (cmp_sum[7:0] == 8'h00) : (cmp_sum[15:0] == 16'h0000);
    assign cmp_flags.c = cmp_carry;
    assign cmp_flags.v = (cmp_sgn_d != cmp_sgn_s) & (cmp_sgn_r != cmp_sgn_d);

    // status with N Z C V replaced, mode bits passed through
    function automatic logic [15:0] put_flags(input logic [15:0] cur, input bfo_flags_t f);
        put_flags               = cur;
        put_flags[NEGATIVE_BIT] = f.n;
        put_flags[ZERO_BIT]     = f.z;
        put_flags[CARRY_BIT]    = f.c;
        put_flags[OVERFLOW_BIT] = f.v;
    endfunction

    // next destination, status and program counter for a single-cycle operation
    logic [15:0] dst_exec, status_exec, pc_exec;
    always_comb begin
        dst_exec    = dst_reg;
        status_exec = status_reg;
        pc_exec     = pc_reg;
        unique case (ctrl_reg.op)
            OP_MOVE:      dst_exec    = dst_hi | src_v;
            OP_BIT_CLEAR: dst_exec    = dst_hi | clr_res;
            OP_BIT_SET:   dst_exec    = dst_hi | set_res;
            OP_BIT_TEST:  status_exec = put_flags(status_reg, and_flags);
            OP_AND: begin
                dst_exec    = dst_hi | and_res;
                status_exec = put_flags(status_reg, and_flags);
            end
            OP_COMPARE:   status_exec = put_flags(status_reg, cmp_flags);
            OP_JUMP:      pc_exec     = dst_reg;
            OP_CALL:      pc_exec     = pc_reg;
            OP_CLEAR:     dst_exec    = dst_hi | (ZERO_WORD & size_mask);
            OP_CARRY_CLR: status_exec = ~CARRY_MASK & status_reg;
            OP_NEG_CLR:   status_exec = ~NEGATIVE_MASK & status_reg;
            OP_ZERO_CLR:  status_exec = ~ZERO_MASK & status_reg;
            default:      dst_exec    = dst_reg;
        endcase
    end

    // sequencer: one execute cycle, then the three call steps for a call only
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:      if (go) begin
                state_next = ST_EXEC;
            end
            ST_EXEC:      state_next = (ctrl_reg.op == OP_CALL) ? ST_CALL_SP : ST_IDLE;
            ST_CALL_SP:   state_next = ST_CALL_PUSH;
            ST_CALL_PUSH: state_next = ST_CALL_PC;
            ST_CALL_PC:   state_next = ST_IDLE;
        endcase
    end

    // state and control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            ctrl_reg  <= '{len_words: 2'b01, byte_op: 1'b0, op: OP_MOVE};
        end else begin
            state_reg <= state_next;
            if (ctrl_load) begin
                ctrl_reg.op      <= bfo_op_t'(s_axi_wdata[CTRL_OP_LSB +: 4]);
                ctrl_reg.byte_op <= s_axi_wdata[CTRL_BYTE_BIT];
            end
            if (ctrl_load & s_axi_wstrb[1]) begin
                ctrl_reg.len_words <= s_axi_wdata[CTRL_LEN_LSB +: 2];
            end
        end
    end

    // operand registers, written by software when idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_reg <= ZERO_WORD;
            dst_reg <= ZERO_WORD;
        end else begin
            if (wr_src) src_reg <= merge16(src_reg, s_axi_wdata, s_axi_wstrb);   // source never written by ops
            if (wr_dst) begin
                dst_reg <= merge16(dst_reg, s_axi_wdata, s_axi_wstrb);
            end else if (state_reg == ST_EXEC) begin
                dst_reg <= dst_exec;
            end
        end
    end

    // status register, program counter, stack pointer and call temporary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= STATUS_RESET;
            pc_reg     <= PC_RESET;
            sp_reg     <= SP_RESET;
            tmp_reg    <= ZERO_WORD;
        end else begin
            if (wr_status) status_reg <= merge16(status_reg, s_axi_wdata, s_axi_wstrb);
            else if (state_reg == ST_EXEC) status_reg <= status_exec;
            if (wr_pc) pc_reg <= merge16(pc_reg, s_axi_wdata, s_axi_wstrb);
            else if (state_reg == ST_EXEC) pc_reg <= pc_exec;
            else if (state_reg == ST_CALL_PC) pc_reg <= tmp_reg;
            if (wr_sp) sp_reg <= merge16(sp_reg, s_axi_wdata, s_axi_wstrb);
            else if (state_reg == ST_CALL_SP) sp_reg <= sp_dec;
            if (state_reg == ST_EXEC) tmp_reg <= dst_reg;
        end
    end

    // stack push of the return address at the new top of stack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            push_addr_reg   <= ZERO_WORD;
            push_data_reg   <= ZERO_WORD;
            push_strobe_reg <= 1'b0;
        end else begin
            push_strobe_reg <= (state_reg == ST_CALL_PUSH);
            if (state_reg == ST_CALL_PUSH) begin
                push_addr_reg <= sp_reg;
                push_data_reg <= ret_addr;
            end
        end
    end

    // write channel: accept address and data together, answer one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            awready_reg <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
            wready_reg  <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read data selection
    logic [15:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_ok   = 1'b1;
        rd_word = ZERO_WORD;
        unique case (s_axi_araddr)
            CTRL_OFS:      rd_word = ctrl_rd;
            SRC_OFS:       rd_word = src_reg;
            DST_OFS:       rd_word = dst_reg;
            STATUS_OFS:    rd_word = status_reg;
            PC_OFS:        rd_word = pc_reg;
            SP_OFS:        rd_word = sp_reg;
            PUSH_ADDR_OFS: rd_word = push_addr_reg;
            PUSH_DATA_OFS: rd_word = push_data_reg;
            default:       rd_ok   = 1'b0;
        endcase
    end

    // read channel: address taken one cycle after arvalid, data one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end else begin
            arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {16'h0000, rd_word};
                rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // busy mirrors the sequencer
    logic busy_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) busy_reg <= 1'b0;
        else busy_reg <= (state_next != ST_IDLE);
    end

    // outputs straight from flip-flops
    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;
    assign busy            = busy_reg;
    assign push_strobe     = push_strobe_reg;
    assign push_addr       = push_addr_reg;
    assign push_data       = push_data_reg;
    assign program_counter = pc_reg;

endmodule // bfo_exec

// File: bfo_pkg.sv
// package: constants, types and register map of the branch/flag execution block
package bfo_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] SRC_OFS       = 8'h04;
    localparam logic [7:0] DST_OFS       = 8'h08;
    localparam logic [7:0] STATUS_OFS    = 8'h0C;
    localparam logic [7:0] PC_OFS        = 8'h10;
    localparam logic [7:0] SP_OFS        = 8'h14;
    localparam logic [7:0] PUSH_ADDR_OFS = 8'h18;
    localparam logic [7:0] PUSH_DATA_OFS = 8'h1C;

    // control register field positions
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_BYTE_BIT = 4;
    localparam int CTRL_GO_BIT   = 8;
    localparam int CTRL_BUSY_BIT = 9;
    localparam int CTRL_LEN_LSB  = 12;

    // status register bit positions
    localparam int CARRY_BIT          = 0;
    localparam int ZERO_BIT           = 1;
    localparam int NEGATIVE_BIT       = 2;
    localparam int OVERFLOW_BIT       = 8;

    // flag-clear masks and reset values
    localparam logic [15:0] CARRY_MASK    = 16'h0001;
    localparam logic [15:0] ZERO_MASK     = 16'h0002;
    localparam logic [15:0] NEGATIVE_MASK = 16'h0004;
    localparam logic [15:0] ZERO_WORD     = 16'h0000;
    localparam logic [15:0] SP_STEP       = 16'h0002;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [15:0] SP_RESET      = 16'h0000;
    localparam logic [15:0] STATUS_RESET  = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // operation codes
    typedef enum logic [3:0] {
        OP_MOVE       = 4'h0,
        OP_BIT_CLEAR  = 4'h1,
        OP_BIT_SET    = 4'h2,
        OP_BIT_TEST   = 4'h3,
        OP_AND        = 4'h4,
        OP_COMPARE    = 4'h5,
        OP_JUMP       = 4'h6,
        OP_CALL       = 4'h7,
        OP_CLEAR      = 4'h8,
        OP_CARRY_CLR  = 4'h9,
        OP_NEG_CLR    = 4'hA,
        OP_ZERO_CLR   = 4'hB
    } bfo_op_t;

    // control register contents
    typedef struct packed {
        logic [1:0] len_words;
        logic       byte_op;
        bfo_op_t    op;
    } bfo_ctrl_t;

    // flag result of an operation: negative, zero, carry, overflow
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } bfo_flags_t;

endpackage

// File: bfo_exec_sva.sv
// assertion checker for the branch/flag execution block, bound to its top module
`timescale 1ns/1ps
module bfo_exec_sva
    import bfo_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        busy,
    input wire logic        push_strobe,
    input wire logic [15:0] program_counter
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus answers follow their handshakes
    property p_b_after; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
    a_b_after: assert property (p_b_after) else $error("no write response after handshake");
    property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_after: assert property (p_r_after) else $error("no read data after handshake");
    property p_aw_w; s_axi_awready |-> s_axi_wready; endproperty
    a_aw_w: assert property (p_aw_w) else $error("address and data accepted apart");
    property p_unmapped; s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h1C |=> s_axi_bresp == RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
    property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read half not zero");
    // program counter only moves by an operation or a software write
    property p_pc_cause;
        $changed(program_counter) |-> $past(busy) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_pc_cause: assert property (p_pc_cause) else $error("program counter moved without cause");
    // return address store is a single pulse inside a running call
    property p_push_pulse; push_strobe |=> !push_strobe; endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("push strobe longer than one cycle");
    property p_push_in_op; push_strobe |-> $past(busy, 2); endproperty
    a_push_in_op: assert property (p_push_in_op) else $error("push outside a call");
    property p_busy_short; $rose(busy) |-> ##[1:6] !busy; endproperty
    a_busy_short: assert property (p_busy_short) else $error("operation never finishes");
    // main scenarios reached
    c_push: cover property (push_strobe);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_op_done: cover property ($fell(busy));
endmodule // bfo_exec_sva

bind bfo_exec bfo_exec_sva u_bfo_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .busy(busy),
    .push_strobe(push_strobe), .program_counter(program_counter)
);

// File: cpu_logic_branch_flag_ops_test.sv
// self-checking testbench for the branch/flag execution block
`timescale 1ns/1ps
module cpu_logic_branch_flag_ops_test;
    import bfo_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, busy, push_strobe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] push_addr, push_data, program_counter;
    int          failures = 0;
    int          num_checks = 0;
    int          npush = 0;
    localparam logic [15:0] SV [4]  = '{16'h7F0F, 16'h8081, 16'hFFFF, 16'h00FF};
    localparam logic [15:0] DV [4]  = '{16'h85F0, 16'h80F1, 16'h8000, 16'hFF00};
    localparam logic [15:0] STV [4] = '{16'hFF07, 16'h0038, 16'h01FF, 16'h0000};

    bfo_exec dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy),
        .push_strobe(push_strobe), .push_addr(push_addr), .push_data(push_data),
        .program_counter(program_counter)
    );

    // clock and push counter
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (push_strobe === 1'b1) npush <= npush + 1;

    task automatic final_report();
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic da;
        logic dw;
        da = 1'b0;
        dw = 1'b0;
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(da && dw)) begin
            @(posedge aclk);
            da = da | (awready === 1'b1);
            dw = dw | (wready === 1'b1);
            if (da) awvalid <= 1'b0;
            if (dw) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    function automatic logic [15:0] ctl(input bfo_op_t op, input logic b, input logic [1:0] n);
        return {2'b00, n, 3'b000, 1'b1, 3'b000, b, op};
    endfunction

    // expected destination and status after one operation
    function automatic logic [31:0] model(input bfo_op_t op, input logic b, input logic [15:0] s, d, st);
        logic [15:0] m, r, nd, ns;
        logic [16:0] sum;
        logic        z, ng, dm, sm;
        m   = b ? 16'h00FF : 16'hFFFF;
        sum = {1'b0, d & m} + {1'b0, ~s & m} + 17'h00001;
        case (op)
            OP_MOVE:      r = s;
            OP_BIT_CLEAR: r = ~s & d;
            OP_BIT_SET:   r = s | d;
            OP_CLEAR:     r = ZERO_WORD;
            OP_COMPARE:   r = sum[15:0];
            default:      r = s & d;
        endcase
        nd = (op inside {OP_MOVE, OP_BIT_CLEAR, OP_BIT_SET, OP_AND, OP_CLEAR}) ? (d & ~m) | (r & m) : d;
        z  = (r & m) == 16'h0000;
        ng = b ? r[7] : r[15];
        dm = b ? d[7] : d[15];
        sm = b ? s[7] : s[15];
        ns = st;
        case (op)
            OP_BIT_TEST, OP_AND, OP_COMPARE: begin
                ns[NEGATIVE_BIT] = ng;
                ns[ZERO_BIT]     = z;
                ns[CARRY_BIT]    = (op == OP_COMPARE) ? (b ? sum[8] : sum[16]) : !z;
                ns[OVERFLOW_BIT] = (op == OP_COMPARE) && (dm != sm) && (ng != dm);
            end
            OP_CARRY_CLR: ns = st & ~CARRY_MASK;
            OP_NEG_CLR:   ns = st & ~NEGATIVE_MASK;
            OP_ZERO_CLR:  ns = st & ~ZERO_MASK;
            default:      ;
        endcase
        return {nd, ns};
    endfunction

    task automatic run(input bfo_op_t op, input logic b, input logic [15:0] s, d, st);
        logic [31:0] e;
        logic [31:0] v;
        e = model(op, b, s, d, st);
        wr(SRC_OFS, s, RESP_OKAY);
        wr(DST_OFS, d, RESP_OKAY);
        wr(STATUS_OFS, st, RESP_OKAY);
        wr(CTRL_OFS, ctl(op, b, 2'd1), RESP_OKAY);
        while (busy !== 1'b0) @(posedge aclk);
        rd(DST_OFS, RESP_OKAY, v);
        chk(v, {16'h0000, e[31:16]});
        rd(SRC_OFS, RESP_OKAY, v);
        chk(v, {16'h0000, s});
        rd(STATUS_OFS, RESP_OKAY, v);
        chk(v, {16'h0000, e[15:0]});
    endtask

    // main sequence
    initial begin
        logic [31:0] v;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CTRL_OFS, RESP_OKAY, v);
        chk(v, 32'h00001000);
        rd(SP_OFS, RESP_OKAY, v);
        chk(v, {16'h0000, SP_RESET});
        // every code but jump and call, both sizes; codes above the last operation must leave destination and status alone
        for (int i = 0; i < 16; i++)
            for (int j = 0; j < 4; j++)
                if (i != 6 && i != 7) run(bfo_op_t'(i[3:0]), j[0], SV[j], DV[j], STV[j]);
        wr(PC_OFS, 16'h1234, RESP_OKAY);
        wr(DST_OFS, 16'hBEEF, RESP_OKAY);
        wr(STATUS_OFS, 16'h0107, RESP_OKAY);
        wr(CTRL_OFS, ctl(OP_JUMP, 1'b0, 2'd1), RESP_OKAY);
        while (busy !== 1'b0) @(posedge aclk);
        chk({16'h0000, program_counter}, 32'h0000BEEF);
        // call from stack pointer zero wraps the push to the top of the space
        wr(PC_OFS, 16'h0100, RESP_OKAY);
        wr(DST_OFS, 16'hC000, RESP_OKAY);
        wr(CTRL_OFS, ctl(OP_CALL, 1'b1, 2'd3), RESP_OKAY);
        while (busy !== 1'b0) @(posedge aclk);
        chk(npush, 32'd1);
        chk({16'h0000, push_addr}, 32'h0000FFFE);
        chk({16'h0000, push_data}, 32'h00000106);
        chk({16'h0000, program_counter}, 32'h0000C000);
        rd(SP_OFS, RESP_OKAY, v);
        chk(v, 32'h0000FFFE);
        rd(STATUS_OFS, RESP_OKAY, v);
        chk(v, 32'h00000107);
        // refused and read-only places
        wr(8'h20, 16'h5555, RESP_SLVERR);
        rd(8'h24, RESP_SLVERR, v);
        chk(v, 32'h0);
        wr(PUSH_ADDR_OFS, 16'h1111, RESP_OKAY);
        rd(PUSH_ADDR_OFS, RESP_OKAY, v);
        chk(v, 32'h0000FFFE);
        // low byte lane only: stack pointer high byte must survive
        wstrb <= 4'h1;
        wr(SP_OFS, 16'h1234, RESP_OKAY);
        wstrb <= 4'hF;
        rd(SP_OFS, RESP_OKAY, v);
        chk(v, 32'h0000FF34);
        final_report();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report();
    end
endmodule // cpu_logic_branch_flag_ops_test
